// ### core/sdm_top.sv
// mode, power and pin control of a 16-bit parallel serial transceiver
//
// Summary of operation
// RULE1 - serial word of twenty bits sent per reference word period
// RULE2 - serial outputs high impedance in loopback, driven otherwise
// RULE3 - serial outputs high impedance throughout power-on reset
// RULE4 - enable low means power-down, only signal detect stays alive; here the transmit buffer also keeps accepting words
// RULE5 - enable rising from power-down passes power-on reset before running
// RULE6 - outside party supplies continuous 75 to 125 MHz reference clock
// RULE7 - transmit flags and word are reference synchronous, registered per word
// RULE8 - lock-to-reference low puts device in transmit-only mode
// RULE9 - lock-to-reference low floats receive word, clock, error and valid pins
// RULE10 - lock-to-reference high: transmit only after receiver sees valid codes
// RULE11 - loopback routes transmitted serial data into the receiver
// RULE12 - outside party keeps loopback low in normal operation
// RULE13 - test enable high: error pin shows pseudorandom pass, high is pass
// RULE14 - received word presented stable at recovered clock rising edge
// RULE15 - receive word outputs high impedance throughout power-on reset
// RULE16 - recovered clock runs at word rate and is low during reset
// RULE17 - in power-down the valid pin follows signal detect, low on loss
// RULE18 - test enable high sends pseudorandom pattern and checks it back
`timescale 1ns/10ps
`default_nettype none
`include "sdm_params.svh"

module sdm_top import sdm_pkg::*; #(
  parameter int POR_CYCLES = `SDM_POR_CYCLES,
  parameter int SYNC_WORDS = `SDM_SYNC_WORDS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // control pins
  input wire logic i_device_enable,
  input wire logic i_lock_to_reference_n,
  input wire logic i_loopback_enable,
  input wire logic i_pseudorandom_test_enable,
  input wire logic i_signal_detect,
  // transmit word side
  input wire logic i_tx_valid,
  input wire logic i_transmit_enable,
  input wire logic i_transmit_error_in,
  input wire logic [`SDM_WORD_W-1:0] i_tx_word,
  output logic o_tx_ready,
  // serial side
  input wire logic [`SDM_FRAME_W-1:0] i_serial_in_pos,
  input wire logic [`SDM_FRAME_W-1:0] i_serial_in_neg,
  output logic [`SDM_FRAME_W-1:0] o_serial_out_pos,
  output logic [`SDM_FRAME_W-1:0] o_serial_out_neg,
  output logic o_serial_out_oe,
  // receive word side
  output logic [`SDM_WORD_W-1:0] o_rx_word,
  output logic o_recovered_clock,
  output logic o_receive_error_flag,
  output logic o_rx_bus_oe,
  output logic o_receive_valid_or_signal_loss,
  output logic o_rx_valid_oe,
  // status
  output logic o_power_down,
  output logic o_por_active,
  output logic o_tx_active
);

  generate
    if (POR_CYCLES < 9 || POR_CYCLES > 255) begin : g_bad_por
      $error("sdm_top: POR_CYCLES must lie in 9..255");
    end
    if (SYNC_WORDS < 1 || SYNC_WORDS > 15) begin : g_bad_sync
      $error("sdm_top: SYNC_WORDS must lie in 1..15");
    end
  endgenerate

  // ***************************************************************
  // control pin synchronisers
  // ***************************************************************
  logic [`SDM_CTL_N-1:0] pin_raw, s1_q, s2_q, s3_q, ctl_q;
  localparam logic [`SDM_CTL_N-1:0] CTL_RST = `SDM_CTL_RST;

  assign pin_raw = {i_device_enable, i_lock_to_reference_n, i_loopback_enable, i_pseudorandom_test_enable,
                    i_signal_detect};

  // a change counts only once stages two and three agree
  for (genvar g = 0; g < `SDM_CTL_N; g++) begin : g_sync
    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        s1_q[g] <= CTL_RST[g];
        s2_q[g] <= CTL_RST[g];
        s3_q[g] <= CTL_RST[g];
        ctl_q[g] <= CTL_RST[g];
      end else begin
        s1_q[g] <= pin_raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        ctl_q[g] <= (s2_q[g] == s3_q[g]) ? s3_q[g] : ctl_q[g];
      end
    end
  end

  logic c_en, c_lockn, c_loop, c_prbs, c_sd;
  assign c_en = ctl_q[`SDM_CTL_EN];
  assign c_lockn = ctl_q[`SDM_CTL_LOCKN];
  assign c_loop = ctl_q[`SDM_CTL_LOOP];
  assign c_prbs = ctl_q[`SDM_CTL_PRBS];
  assign c_sd = ctl_q[`SDM_CTL_SD];

  // ***************************************************************
  // power sequencing
  // ***************************************************************
  sdm_pwr_t pwr_q, pwr_d;
  logic [7:0] por_cnt_q;
  logic phase_q, run, tick;

  // leaving power-down always goes through a full reset interval
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      SDM_PWR_DOWN: if (c_en) pwr_d = SDM_PWR_POR; // RULE5
      SDM_PWR_POR: begin
        if (!c_en) pwr_d = SDM_PWR_DOWN;
        else if (por_cnt_q == 8'h00) pwr_d = SDM_PWR_RUN;
      end
      SDM_PWR_RUN: if (!c_en) pwr_d = SDM_PWR_DOWN; // RULE4
      default: pwr_d = SDM_PWR_DOWN;
    endcase
  end

  assign run = (pwr_q == SDM_PWR_RUN);
  assign tick = run && phase_q;

  // state, reset counter and word phase (two clocks per word)
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr_q <= SDM_PWR_DOWN;
      por_cnt_q <= 8'(POR_CYCLES - 1);
      phase_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      por_cnt_q <= (pwr_q == SDM_PWR_POR) ? por_cnt_q - 8'h01 : 8'(POR_CYCLES - 1);
      phase_q <= run && !phase_q;
    end
  end

  // ***************************************************************
  // transmit path: buffer then serial word
  // ***************************************************************
  sdm_buf_if #(.WIDTH(`SDM_WORD_W + 2)) tx_if ();
  sdm_frame_t tx_frame_q, tx_frame_n_q, tx_frame_d;
  logic synced_q, tx_act, pop;

  sdm_buf #(.WIDTH(`SDM_WORD_W + 2)) u_buf (.i_clock(i_clock), .i_arst_n(i_arst_n), .bus(tx_if.buf_mp));

  // transmit-only mode needs no link sync; normal mode waits for it
  assign tx_act = run && (!c_lockn || synced_q); // RULE8 RULE10
  assign tx_if.wr_valid = i_tx_valid;
  assign tx_if.wr_data = {i_transmit_enable, i_transmit_error_in, i_tx_word}; // RULE7
  assign tx_if.rd_ready = tick && tx_act && !c_prbs;
  assign pop = tx_if.rd_ready && tx_if.rd_valid;
  assign o_tx_ready = tx_if.wr_ready;

  // one frame per word period; idle frames keep the far end in sync
  assign tx_frame_d = !run ? sdm_frame(1'b0, 1'b0, '0) :
                      !tick ? tx_frame_q :
                      c_prbs ? sdm_prbs_next(tx_frame_q[`SDM_PRBS_W-1:0]) : // RULE18
                      pop ? sdm_frame(tx_if.rd_data[17], tx_if.rd_data[16], tx_if.rd_data[15:0]) : // RULE7
                      sdm_frame(1'b0, 1'b0, '0);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_frame_q <= '0;
      tx_frame_n_q <= '1;
      o_serial_out_oe <= 1'b0;
    end else begin
      tx_frame_q <= tx_frame_d; // RULE1
      tx_frame_n_q <= ~tx_frame_d;
      o_serial_out_oe <= (pwr_d == SDM_PWR_RUN) && run && !c_loop; // RULE2 RULE3
    end
  end

  assign o_serial_out_pos = tx_frame_q;
  assign o_serial_out_neg = tx_frame_n_q;

  // ***************************************************************
  // receive path
  // ***************************************************************
  sdm_frame_t rx_src, prev_q;
  logic rx_run, sd_eff, code_ok, prbs_match;
  logic [3:0] sync_cnt_q;

  // loopback takes the transmit frame and ignores the pins
  assign rx_src = c_loop ? tx_frame_q : i_serial_in_pos; // RULE11
  assign sd_eff = c_loop || c_sd;
  assign code_ok = c_loop || ((i_serial_in_pos == ~i_serial_in_neg) && rx_src[`SDM_FRM_MARK] &&
                   (rx_src[`SDM_FRM_PAR] == ^rx_src[15:0]));
  assign prbs_match = (rx_src == sdm_prbs_next(prev_q[`SDM_PRBS_W-1:0])); // RULE18
  assign rx_run = run && c_lockn;

  // link sync: consecutive good codes, lost only on leaving run
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_cnt_q <= 4'h0;
      synced_q <= 1'b0;
      prev_q <= '0;
    end else if (!rx_run) begin
      sync_cnt_q <= 4'h0;
      synced_q <= synced_q && run;
    end else if (tick) begin
      prev_q <= rx_src;
      sync_cnt_q <= code_ok ? ((sync_cnt_q == 4'hF) ? sync_cnt_q : sync_cnt_q + 4'h1) : 4'h0;
      synced_q <= synced_q || (code_ok && sync_cnt_q >= 4'(SYNC_WORDS - 1)); // RULE10
    end
  end

  // pin outputs; word changes with clock low so it is stable at the rise
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_word <= '0;
      o_recovered_clock <= 1'b0;
      o_receive_error_flag <= 1'b0;
      o_rx_bus_oe <= 1'b0;
      o_receive_valid_or_signal_loss <= 1'b0;
      o_rx_valid_oe <= 1'b0;
    end else begin
      o_recovered_clock <= rx_run && !phase_q; // RULE16
      o_rx_bus_oe <= rx_run; // RULE9 RULE15
      o_rx_valid_oe <= rx_run || (pwr_q == SDM_PWR_DOWN);
      if (pwr_q == SDM_PWR_DOWN) begin
        o_receive_valid_or_signal_loss <= c_sd; // RULE17
      end else if (!rx_run) begin
        o_receive_valid_or_signal_loss <= 1'b0;
      end else if (tick) begin
        o_rx_word <= sd_eff ? rx_src[15:0] : `SDM_RX_LOS_WORD; // RULE14
        o_receive_valid_or_signal_loss <= !sd_eff || (code_ok && rx_src[`SDM_FRM_EN]);
        o_receive_error_flag <= c_prbs ? prbs_match : // RULE13
                                (!sd_eff || !code_ok || rx_src[`SDM_FRM_ER]);
      end
    end
  end

  // status pins; done flag keeps checks off the edge that still sees reset
  logic rst_done_q;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_power_down <= 1'b1;
      o_por_active <= 1'b0;
      o_tx_active <= 1'b0;
      rst_done_q <= 1'b0;
    end else begin
      o_power_down <= (pwr_q == SDM_PWR_DOWN); // RULE4
      o_por_active <= (pwr_q == SDM_PWR_POR);
      o_tx_active <= tx_act;
      rst_done_q <= 1'b1;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n || !rst_done_q);

  property p_loop_hiz; c_loop |=> !o_serial_out_oe; endproperty
  a_loop_hiz: assert property (p_loop_hiz) else $error("serial out driven in loopback"); // RULE2
  property p_drive; (run && pwr_d == SDM_PWR_RUN && !c_loop) |=> o_serial_out_oe; endproperty
  a_drive: assert property (p_drive) else $error("serial out not driven in run"); // RULE2
  property p_por_hiz; (pwr_q == SDM_PWR_POR) |=> !o_serial_out_oe && !o_rx_bus_oe && !o_recovered_clock; endproperty
  a_por_hiz: assert property (p_por_hiz) else $error("pins active during reset"); // RULE3
  property p_pd; !c_en ##1 !c_en |=> o_power_down; endproperty
  a_pd: assert property (p_pd) else $error("no power-down with enable low"); // RULE4
  property p_por_seq; (pwr_q == SDM_PWR_DOWN && c_en) |=> (pwr_q == SDM_PWR_POR) [*8]; endproperty
  a_por_seq: assert property (p_por_seq) else $error("enable skipped reset"); // RULE5
  property p_lock_hiz; !c_lockn |=> !o_rx_bus_oe && !o_recovered_clock; endproperty
  a_lock_hiz: assert property (p_lock_hiz) else $error("receive pins driven in transmit-only"); // RULE9
  property p_tx_gate; (c_lockn && !synced_q) |-> !pop; endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("word sent before sync"); // RULE10
  property p_prbs_pin; (tick && rx_run && c_prbs) |=> (o_receive_error_flag == $past(prbs_match)); endproperty
  a_prbs_pin: assert property (p_prbs_pin) else $error("test result not on error pin"); // RULE13
  property p_rx_stable; (rx_run && $changed(o_rx_word)) |-> !o_recovered_clock ##1 o_recovered_clock; endproperty
  a_rx_stable: assert property (p_rx_stable) else $error("word not stable at clock rise"); // RULE14
  property p_rxclk; (rx_run && o_recovered_clock && $past(rx_run)) |=> !o_recovered_clock; endproperty
  a_rxclk: assert property (p_rxclk) else $error("recovered clock rate wrong"); // RULE16
  property p_pd_sd; (pwr_q == SDM_PWR_DOWN) |=> o_rx_valid_oe && (o_receive_valid_or_signal_loss == $past(c_sd));
  endproperty
  a_pd_sd: assert property (p_pd_sd) else $error("valid pin not following detect"); // RULE17
  property p_capture; pop |=> tx_frame_q[15:0] == $past(tx_if.rd_data[15:0]); endproperty
  a_capture: assert property (p_capture) else $error("transmit word not registered"); // RULE7

  c_sync: cover property (rx_run && !synced_q ##1 synced_q);
  c_loop_rx: cover property (c_loop && tick && rx_run && o_tx_active);
  c_pseudorandom_test_ok: cover property (c_prbs && o_receive_error_flag && o_rx_bus_oe);
  c_full: cover property (run && !o_tx_ready && i_tx_valid);

endmodule

`default_nettype wire

// ### common/sdm_params.svh
// constants for the serdes mode and pin control block
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH

// ***************************************************************
// clock and timing
// ***************************************************************
`define SDM_CLK_MHZ 250
`define SDM_POR_NS 100
`define SDM_POR_CYCLES ((`SDM_POR_NS * `SDM_CLK_MHZ + 999) / 1000)
`define SDM_SYNC_WORDS 3
`define SDM_SERIAL_RATIO 20

// ***************************************************************
// widths and frame layout (bit positions in a 20-bit serial word)
// ***************************************************************
`define SDM_WORD_W 16
`define SDM_FRAME_W 20
`define SDM_FRM_EN 19
`define SDM_FRM_ER 18
`define SDM_FRM_PAR 17
`define SDM_FRM_MARK 16
`define SDM_PRBS_W 7

// ***************************************************************
// control pin vector positions and reset value
// ***************************************************************
`define SDM_CTL_N 5
`define SDM_CTL_EN 4
`define SDM_CTL_LOCKN 3
`define SDM_CTL_LOOP 2
`define SDM_CTL_PRBS 1
`define SDM_CTL_SD 0
`define SDM_CTL_RST 5'h08
`define SDM_RX_LOS_WORD 16'hFFFF

`endif

// ### common/sdm_pkg.sv
// types and shared coding functions for the serdes mode and pin control block
`default_nettype none
`include "sdm_params.svh"

package sdm_pkg;

  // power sequencing states
  typedef enum logic [1:0] {
    SDM_PWR_DOWN = 2'b00,
    SDM_PWR_POR = 2'b01,
    SDM_PWR_RUN = 2'b10
  } sdm_pwr_t;

  typedef logic [`SDM_FRAME_W-1:0] sdm_frame_t;

  // build one serial word from a parallel word and its flags
  function automatic sdm_frame_t sdm_frame(input logic en, input logic er, input logic [`SDM_WORD_W-1:0] d);
    sdm_frame = {en, er, ^d, 1'b1, d};
  endfunction

  // next 20 bits of the x^7+x^6+1 sequence, first bit in the top position
  function automatic sdm_frame_t sdm_prbs_next(input logic [`SDM_PRBS_W-1:0] seed);
    logic [`SDM_PRBS_W-1:0] s;
    sdm_frame_t o;
    s = (seed == '0) ? {`SDM_PRBS_W{1'b1}} : seed;
    o = '0;
    for (int i = 0; i < `SDM_FRAME_W; i++) begin
      s = {s[`SDM_PRBS_W-2:0], s[6] ^ s[5]};
      o[`SDM_FRAME_W-1-i] = s[0];
    end
    sdm_prbs_next = o;
  endfunction

endpackage

`default_nettype wire

// ### common/sdm_buf_if.sv
// valid/ready carrier between the control block and its transmit buffer
`timescale 1ns/10ps
`default_nettype none

interface sdm_buf_if #(parameter int WIDTH = 18);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport buf_mp (input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
  modport user_mp (output wr_valid, output wr_data, output rd_ready, input wr_ready, input rd_valid, input rd_data);
endinterface

`default_nettype wire

// ### core/sdm_buf.sv
// two-entry transmit word buffer with registered ready
`timescale 1ns/10ps
`default_nettype none

module sdm_buf #(
  parameter int WIDTH = 18
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // buffer ports
  sdm_buf_if.buf_mp bus
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("sdm_buf: WIDTH must be at least one");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic wr_ready_q;
  logic push;
  logic pop;

  // handshakes; ready is registered so the source sees no long path
  assign push = bus.wr_valid && wr_ready_q;
  assign pop = bus.rd_ready && (count_q != 2'h0);
  assign count_d = 2'(count_q + {1'b0, push} - {1'b0, pop});
  assign bus.wr_ready = wr_ready_q;
  assign bus.rd_valid = (count_q != 2'h0);
  assign bus.rd_data = mem_q[rd_ptr_q];

  // storage has no reset, only pointers, count and ready do
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= bus.wr_data;
    end
  end

  // pointers, occupancy and ready
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      wr_ready_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_d;
      wr_ready_q <= (count_d != 2'h2);
    end
  end

endmodule

`default_nettype wire

// ### verif/sdm_line_partner.sv
// far-end line model: a cable that echoes the serial outputs back into the inputs
`timescale 1ns/10ps
`default_nettype none
`include "sdm_params.svh"

module sdm_line_partner (
  // clock
  input wire logic i_clock,
  // from the block's serial outputs
  input wire logic [`SDM_FRAME_W-1:0] i_out_pos,
  input wire logic i_out_oe,
  // to the block's serial inputs
  output logic [`SDM_FRAME_W-1:0] o_in_pos,
  output logic [`SDM_FRAME_W-1:0] o_in_neg
);
  logic [`SDM_FRAME_W-1:0] float_q = '0;

  // a released line must not keep showing the last frame, so it flips every cycle
  always_ff @(posedge i_clock) begin
    float_q <= i_out_oe ? ~i_out_pos : ~float_q;
  end

  // echo while driven; the pair always stays complementary
  assign o_in_pos = i_out_oe ? i_out_pos : float_q;
  assign o_in_neg = ~o_in_pos;
endmodule

`default_nettype wire

// ### verif/sdm_top_bench.sv
// self-checking bench for the serdes mode and pin control block
`timescale 1ns/10ps
`default_nettype none
`include "sdm_params.svh"

module sdm_top_bench;
  // short power-on count keeps the run brief
  localparam int POR = 10;
  logic i_clock = 1'b0, i_arst_n = 1'b0, i_device_enable = 1'b0, i_lock_to_reference_n = 1'b1;
  logic i_loopback_enable = 1'b0, i_pseudorandom_test_enable = 1'b0, i_signal_detect = 1'b0;
  logic i_tx_valid = 1'b0, i_transmit_enable = 1'b0, i_transmit_error_in = 1'b0;
  logic [15:0] i_tx_word = 16'h0000;
  logic [15:0] o_rx_word;
  logic [19:0] i_serial_in_pos, i_serial_in_neg, o_serial_out_pos, o_serial_out_neg;
  logic o_tx_ready, o_serial_out_oe, o_recovered_clock, o_receive_error_flag, o_rx_bus_oe;
  logic o_receive_valid_or_signal_loss, o_rx_valid_oe, o_power_down, o_por_active, o_tx_active;
  int num_errors = 0;
  int check_count = 0;

  // ***************************************************************
  // clock, design and far end
  // ***************************************************************
  // free-running clock; two cycles per word gives the word rate
  always #2 i_clock = ~i_clock;

  sdm_top #(.POR_CYCLES(POR), .SYNC_WORDS(3)) dut_u (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_device_enable(i_device_enable),
    .i_lock_to_reference_n(i_lock_to_reference_n), .i_loopback_enable(i_loopback_enable),
    .i_pseudorandom_test_enable(i_pseudorandom_test_enable), .i_signal_detect(i_signal_detect),
    .i_tx_valid(i_tx_valid), .i_transmit_enable(i_transmit_enable), .i_transmit_error_in(i_transmit_error_in),
    .i_tx_word(i_tx_word), .o_tx_ready(o_tx_ready), .i_serial_in_pos(i_serial_in_pos),
    .i_serial_in_neg(i_serial_in_neg), .o_serial_out_pos(o_serial_out_pos), .o_serial_out_neg(o_serial_out_neg),
    .o_serial_out_oe(o_serial_out_oe), .o_rx_word(o_rx_word), .o_recovered_clock(o_recovered_clock),
    .o_receive_error_flag(o_receive_error_flag), .o_rx_bus_oe(o_rx_bus_oe),
    .o_receive_valid_or_signal_loss(o_receive_valid_or_signal_loss), .o_rx_valid_oe(o_rx_valid_oe),
    .o_power_down(o_power_down), .o_por_active(o_por_active), .o_tx_active(o_tx_active));

  sdm_line_partner line_u (
    .i_clock(i_clock), .i_out_pos(o_serial_out_pos), .i_out_oe(o_serial_out_oe),
    .o_in_pos(i_serial_in_pos), .o_in_neg(i_serial_in_neg));

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // status levels picked by number, so one wait loop serves them all
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = o_por_active;
      1: pick = o_tx_active;
      2: pick = o_power_down;
      3: pick = o_serial_out_oe;
      4: pick = o_tx_ready;
      default: pick = o_receive_valid_or_signal_loss;
    endcase
  endfunction

  task automatic wait_for(input int sel, input logic v, input string nm, input int max);
    int k;
    k = 0;
    do begin
      @(negedge i_clock);
      k++;
    end while (k < max && pick(sel) !== v);
    check(nm, pick(sel), v);
  endtask

  // control pins change together just after a rising edge
  task automatic set_ctl(input logic en, input logic lck, input logic lp, input logic pr, input logic sd);
    @(posedge i_clock);
    i_device_enable <= en;
    i_lock_to_reference_n <= lck;
    i_loopback_enable <= lp;
    i_pseudorandom_test_enable <= pr;
    i_signal_detect <= sd;
  endtask

  // offer one word and hold it until ready is seen high at an edge
  task automatic send(input logic en, input logic er, input logic [15:0] d);
    int k;
    @(posedge i_clock);
    i_tx_valid <= 1'b1;
    i_transmit_enable <= en;
    i_transmit_error_in <= er;
    i_tx_word <= d;
    k = 0;
    do begin
      @(negedge i_clock);
      k++;
    end while (k < 200 && o_tx_ready !== 1'b1);
    check("tx_ready", o_tx_ready, 1'b1);
    @(posedge i_clock);
    i_tx_valid <= 1'b0;
  endtask

  task automatic see_frame(input logic en, input logic er, input logic [15:0] d);
    logic [19:0] f;
    int k;
    f = {en, er, ^d, 1'b1, d};
    for (k = 0; k < 40 && o_serial_out_pos !== f; k++) @(negedge i_clock);
    check("serial_pos", o_serial_out_pos, f);
    check("serial_neg", o_serial_out_neg, ~f);
  endtask

  task automatic rx_expect(input logic [15:0] d, input logic err);
    int k;
    k = 0;
    do begin
      @(negedge i_clock);
      k++;
    end while (k < 80 && !(o_rx_word === d && o_recovered_clock === 1'b0));
    check("rx_word", o_rx_word, d);
    check("rx_error", o_receive_error_flag, err);
    check("rx_valid", o_receive_valid_or_signal_loss, 1'b1);
    @(negedge i_clock);
    check("rx_clock_high", o_recovered_clock, 1'b1);
    check("rx_word_held", o_rx_word, d);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    repeat (10) @(negedge i_clock);
    check("serial_oe_rst", o_serial_out_oe, 1'b0);
    check("rx_bus_oe_rst", o_rx_bus_oe, 1'b0);
    check("rx_clock_rst", o_recovered_clock, 1'b0);
    check("power_down_rst", o_power_down, 1'b1);
    repeat (6) @(posedge i_clock);
    i_arst_n <= 1'b1;
  endtask

  // enable from power-down must pass through a full power-on reset first
  task automatic t_power_up();
    int n;
    set_ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    wait_for(0, 1'b1, "por_start", 12);
    for (n = 0; n < 100 && o_por_active === 1'b1; n++) begin
      check("serial_oe_por", o_serial_out_oe, 1'b0);
      check("rx_bus_oe_por", o_rx_bus_oe, 1'b0);
      @(negedge i_clock);
    end
    check("por_length", (n >= POR - 1 && n <= POR + 1), 1'b1);
    check("tx_before_sync", o_tx_active, 1'b0);
    check("power_down_run", o_power_down, 1'b0);
    wait_for(1, 1'b1, "tx_after_sync", 40);
  endtask

  task automatic t_loopback();
    int n;
    int k;
    logic prev;
    check("serial_oe_loop", o_serial_out_oe, 1'b0);
    n = 0;
    for (k = 0; k < 20; k++) begin
      prev = o_recovered_clock;
      @(negedge i_clock);
      if (prev === 1'b0 && o_recovered_clock === 1'b1) n++;
    end
    check("rx_clock_rises", 20'(n), 20'd10);
    send(1'b1, 1'b0, 16'hA5C3);
    rx_expect(16'hA5C3, 1'b0);
    send(1'b1, 1'b1, 16'h0F0E);
    rx_expect(16'h0F0E, 1'b1);
  endtask

  task automatic t_external();
    set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    wait_for(3, 1'b1, "serial_oe_on", 12);
    send(1'b1, 1'b0, 16'h8001);
    see_frame(1'b1, 1'b0, 16'h8001);
    rx_expect(16'h8001, 1'b0);
  endtask

  task automatic t_prbs();
    set_ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    repeat (30) @(negedge i_clock);
    check("pseudorandom_test_ok", o_receive_error_flag, 1'b1);
    check("prbs_not_idle", o_serial_out_pos === 20'h10000, 1'b0);
    set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge i_clock);
  endtask

  task automatic t_lock_ref();
    set_ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (6) @(negedge i_clock);
    check("rx_bus_oe_lock", o_rx_bus_oe, 1'b0);
    check("rx_valid_oe_lock", o_rx_valid_oe, 1'b0);
    check("tx_only", o_tx_active, 1'b1);
    send(1'b1, 1'b1, 16'h3C5A);
    see_frame(1'b1, 1'b1, 16'h3C5A);
  endtask

  // words offered while powered down wait in the buffer and are not lost
  task automatic t_power_down();
    set_ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    wait_for(2, 1'b1, "power_down", 20);
    check("serial_oe_pd", o_serial_out_oe, 1'b0);
    check("rx_valid_oe_pd", o_rx_valid_oe, 1'b1);
    wait_for(5, 1'b1, "detect_high", 10);
    set_ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    wait_for(5, 1'b0, "detect_loss", 10);
    send(1'b1, 1'b0, 16'h1234);
    send(1'b1, 1'b0, 16'hFEDC);
    repeat (3) @(negedge i_clock);
    check("buffer_full", o_tx_ready, 1'b0);
    set_ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    wait_for(0, 1'b1, "por_again", 12);
    wait_for(4, 1'b1, "buffer_drains", 100);
    rx_expect(16'h1234, 1'b0);
    rx_expect(16'hFEDC, 1'b0);
  endtask

  // ***************************************************************
  // run and verdict
  // ***************************************************************
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clock);
    num_errors++;
    summarize();
  end

  initial begin
    t_reset();
    repeat (3) @(posedge i_clock);
    t_power_up();
    t_loopback();
    t_external();
    t_prbs();
    t_lock_ref();
    t_power_down();
    summarize();
  end
endmodule

`default_nettype wire
